// *** pkg/dmfe_pkg.sv ***
`default_nettype none
package dmfe_pkg;
	// clocking of the phase clock that we drive to the microphones
	localparam int unsigned SYS_CLK_HZ = 25_000_000;
	localparam int unsigned MIC_CLK_HZ = 2_500_000;
	localparam int unsigned HALF_CYC = SYS_CLK_HZ / (2 * MIC_CLK_HZ);
	localparam int unsigned SYNC_LAT = 2;
	localparam int unsigned MID_CYC = HALF_CYC / 2;
	localparam int unsigned PICK_CYC = MID_CYC + SYNC_LAT;
	// oversampling and sample format
	localparam int unsigned OSR_HI = 128;
	localparam int unsigned OSR_LO = 64;
	localparam int unsigned SAMPLE_W = 24;
	localparam int unsigned HALF_HI = OSR_HI / 2;
	localparam int unsigned HALF_LO = OSR_LO / 2;
	localparam int unsigned SH_HI = SAMPLE_W - 1 - $clog2(HALF_HI);
	localparam int unsigned SH_LO = SAMPLE_W - 1 - $clog2(HALF_LO);
	localparam int unsigned MANT_FRAC = 15;
	localparam int unsigned STEP_BITS = 4;
	// apb map: byte address is four times the index
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W = ADDR_W - 2;
	localparam logic [IDX_W-1:0] IDX_CONV_ENA = 10'h012;
	localparam logic [IDX_W-1:0] IDX_VOL_L = 10'h024;
	localparam logic [IDX_W-1:0] IDX_VOL_R = 10'h025;
	localparam logic [IDX_W-1:0] IDX_SRC_SEL = 10'h0A4;
	localparam logic [IDX_W-1:0] IDX_CFG = 10'h0A6;
	localparam logic [IDX_W-1:0] IDX_STAT = 10'h0A7;
	// field positions
	localparam int unsigned BIT_RIGHT_ON = 0;
	localparam int unsigned BIT_LEFT_ON = 1;
	localparam int unsigned BIT_VU = 8;
	localparam int unsigned BIT_SRC = 9;
	localparam int unsigned BIT_OSR64 = 0;
	localparam int unsigned BIT_CLK_ON = 1;
	localparam int unsigned BIT_OVR = 0;
	localparam int unsigned BIT_PEND = 1;
	localparam int unsigned VOL_W = 8;
	// volume codes
	localparam logic [VOL_W-1:0] VOL_RESET = 8'hC0;
	localparam logic [VOL_W-1:0] VOL_MUTE = 8'h00;
	localparam logic [VOL_W-1:0] VOL_TOP = 8'hEF;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} dmfe_pair_t;

	typedef struct packed {
		logic [VOL_W-1:0] left;
		logic [VOL_W-1:0] right;
	} dmfe_gain_t;
endpackage
`default_nettype wire

// *** src/dmfe_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmfe_buf #(
	parameter int unsigned W = 48,
	parameter int unsigned DEPTH = 2
) (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic [DEPTH-1:0] vld;
		logic [DEPTH-1:0][W-1:0] mem;
	} dmfe_buf_st_t;

	dmfe_buf_st_t q, n;

	// head always sits in slot 0, so the outputs are plain flops
	assign out_valid = q.vld[0];
	assign out_data = q.mem[0];
	assign in_ready = !q.vld[DEPTH-1];

	// shift down on pop, then drop the new word in the first free slot
	always_comb begin
		logic placed;
		placed = 1'b0;
		n = q;
		if (q.vld[0] && out_ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				n.mem[i] = q.mem[i+1];
				n.vld[i] = q.vld[i+1];
			end
			n.vld[DEPTH-1] = 1'b0;
		end
		if (in_valid && in_ready) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!n.vld[i] && !placed) begin
					n.mem[i] = in_data;
					n.vld[i] = 1'b1;
					placed = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// *** src/dmfe_gain.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmfe_gain (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// samples in, gains applied to them
	input wire logic in_valid,
	input wire dmfe_pkg::dmfe_pair_t in_pair,
	input wire dmfe_pkg::dmfe_gain_t gains,
	output logic in_ready,
	// scaled samples out
	output logic out_valid,
	output dmfe_pkg::dmfe_pair_t out_pair,
	input wire logic out_ready
);
	typedef struct packed {
		logic vld;
		dmfe_pkg::dmfe_pair_t pair;
	} dmfe_gain_st_t;

	dmfe_gain_st_t q, n;

	// 2^(k/16) in Q15; 16 steps of 0.375 dB make one 6 dB octave
	function automatic logic [15:0] mant(input logic [3:0] k);
		case (k)
			4'h0: mant = 16'h8000;
			4'h1: mant = 16'h85AB;
			4'h2: mant = 16'h8B96;
			4'h3: mant = 16'h91C4;
			4'h4: mant = 16'h9838;
			4'h5: mant = 16'h9EF5;
			4'h6: mant = 16'hA5FF;
			4'h7: mant = 16'hAD58;
			4'h8: mant = 16'hB505;
			4'h9: mant = 16'hBD09;
			4'hA: mant = 16'hC567;
			4'hB: mant = 16'hCE25;
			4'hC: mant = 16'hD745;
			4'hD: mant = 16'hE0CD;
			4'hE: mant = 16'hEAC1;
			default: mant = 16'hF525;
		endcase
	endfunction

	// code to gain: shift by whole octaves, mantissa for the rest
	function automatic logic signed [23:0] scale(
		input logic signed [23:0] s, input logic [7:0] code);
		logic [7:0] c;
		logic signed [9:0] e;
		logic signed [5:0] sh;
		logic signed [47:0] p;
		c = (code > dmfe_pkg::VOL_TOP) ? dmfe_pkg::VOL_TOP : code;
		e = signed'({2'h0, c}) - signed'({2'h0, dmfe_pkg::VOL_RESET});
		sh = e[9:dmfe_pkg::STEP_BITS];
		p = 48'(s);
		p = p * signed'(48'(mant(e[dmfe_pkg::STEP_BITS-1:0])));
		if (sh >= 0) begin
			p = p <<< sh;
		end else begin
			p = p >>> 6'(-sh);
		end
		p = p >>> dmfe_pkg::MANT_FRAC;
		if (p > 48'sh0000007FFFFF) begin
			p = 48'sh0000007FFFFF;
		end else if (p < -48'sh000000800000) begin
			p = -48'sh000000800000;
		end
		if (code == dmfe_pkg::VOL_MUTE) begin
			p = '0;
		end
		scale = p[23:0];
	endfunction

	assign in_ready = !q.vld || out_ready;
	assign out_valid = q.vld;
	assign out_pair = q.pair;

	// one pipeline stage; both channels share one gain snapshot
	always_comb begin
		n = q;
		if (in_ready) begin
			n.vld = in_valid;
			n.pair.left = scale(in_pair.left, gains.left);
			n.pair.right = scale(in_pair.right, gains.right);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// *** src/dmfe_top.sv ***
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dmfe_top (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic [dmfe_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// microphone link
	input wire logic mic_serial_in,
	output logic mic_phase_clock,
	// internal converters
	input wire logic conv_valid,
	input wire dmfe_pkg::dmfe_pair_t conv_pair,
	output logic left_conv_on,
	output logic right_conv_on,
	output logic conv_osr64,
	// record stream
	output wire logic rec_valid,
	output wire dmfe_pkg::dmfe_pair_t rec_pair,
	input wire logic rec_ready
);
	localparam int unsigned CNT_W = $clog2(dmfe_pkg::HALF_CYC);
	localparam int unsigned OSR_W = $clog2(dmfe_pkg::OSR_HI) + 1;
	localparam int unsigned IW = dmfe_pkg::IDX_W;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic left_on;
		logic right_on;
		logic src_mic;
		logic osr64;
		logic clk_on;
		dmfe_pkg::dmfe_gain_t stored;
		dmfe_pkg::dmfe_gain_t active;
		logic pend;
		logic ovr;
		logic [1:0] sync;
		logic [CNT_W-1:0] div;
		logic phase;
		// set by the first high-phase bit after the clock starts
		logic armed;
		logic [OSR_W-1:0] ones_l;
		logic [OSR_W-1:0] ones_r;
		logic [OSR_W-1:0] nbits;
		logic smp_vld;
		dmfe_pkg::dmfe_pair_t smp;
	} dmfe_top_st_t;

	dmfe_top_st_t q, n;
	logic [IW-1:0] idx;
	logic mapped;
	logic [31:0] rd_word;
	logic wr_take;
	logic src_valid;
	dmfe_pkg::dmfe_pair_t src_pair;
	dmfe_pkg::dmfe_pair_t gated;
	logic g_ready;
	logic g_valid;
	dmfe_pkg::dmfe_pair_t g_pair;
	logic b_ready;
	logic boundary;
	logic [OSR_W-1:0] osr_now;

	// count of ones over one frame to a signed full-scale sample
	function automatic logic signed [23:0] to_pcm(
		input logic [OSR_W-1:0] ones, input logic lo);
		logic signed [24:0] v;
		v = signed'(25'(ones));
		if (lo) begin
			v = v - 25'sh0000000 - 25'(dmfe_pkg::HALF_LO);
			v = v <<< dmfe_pkg::SH_LO;
		end else begin
			v = v - 25'(dmfe_pkg::HALF_HI);
			v = v <<< dmfe_pkg::SH_HI;
		end
		// a frame of all ones would wrap to the negative end
		if (v > 25'sh07FFFFF) begin
			v = 25'sh07FFFFF;
		end
		to_pcm = v[23:0];
	endfunction

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign mic_phase_clock = q.phase;
	assign left_conv_on = q.left_on;
	assign right_conv_on = q.right_on;
	assign conv_osr64 = q.osr64;

	// address decode; the low two address bits are ignored
	assign idx = paddr[dmfe_pkg::ADDR_W-1:2];
	assign mapped = (idx == dmfe_pkg::IDX_CONV_ENA) ||
		(idx == dmfe_pkg::IDX_VOL_L) || (idx == dmfe_pkg::IDX_VOL_R) ||
		(idx == dmfe_pkg::IDX_SRC_SEL) || (idx == dmfe_pkg::IDX_CFG) ||
		(idx == dmfe_pkg::IDX_STAT);
	// writes land only at the access edge, and never on an unmapped index
	assign wr_take = psel && penable && pwrite && q.pready && !q.pslverr;

	// read mux; the update bit is a strobe and always reads 0
	always_comb begin
		rd_word = '0;
		case (idx)
			dmfe_pkg::IDX_CONV_ENA: begin
				rd_word[dmfe_pkg::BIT_LEFT_ON] = q.left_on;
				rd_word[dmfe_pkg::BIT_RIGHT_ON] = q.right_on;
			end
			dmfe_pkg::IDX_VOL_L: begin
				rd_word[dmfe_pkg::VOL_W-1:0] = q.stored.left;
			end
			dmfe_pkg::IDX_VOL_R: begin
				rd_word[dmfe_pkg::VOL_W-1:0] = q.stored.right;
			end
			dmfe_pkg::IDX_SRC_SEL: begin
				rd_word[dmfe_pkg::BIT_SRC] = q.src_mic;
			end
			dmfe_pkg::IDX_CFG: begin
				rd_word[dmfe_pkg::BIT_OSR64] = q.osr64;
				rd_word[dmfe_pkg::BIT_CLK_ON] = q.clk_on;
			end
			dmfe_pkg::IDX_STAT: begin
				rd_word[dmfe_pkg::BIT_OVR] = q.ovr;
				rd_word[dmfe_pkg::BIT_PEND] = q.pend;
			end
			default: rd_word = '0;
		endcase
	end

	// source select, then channel gating by the converter enables
	assign src_valid = q.src_mic ? q.smp_vld : conv_valid;
	assign src_pair = q.src_mic ? q.smp : conv_pair;
	assign gated.left = q.left_on ? src_pair.left : '0;
	assign gated.right = q.right_on ? src_pair.right : '0;
	assign boundary = src_valid && g_ready;
	assign osr_now = q.osr64 ? OSR_W'(dmfe_pkg::OSR_LO) :
		OSR_W'(dmfe_pkg::OSR_HI);

	always_comb begin
		n = q;
		// first flop only feeds the second
		n.sync = {q.sync[0], mic_serial_in};
		n.smp_vld = 1'b0;

		// apb: answer is prepared in setup, so access has one cycle
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.pslverr = !mapped;
			n.prdata = rd_word;
		end
		if (wr_take) begin
			case (idx)
				dmfe_pkg::IDX_CONV_ENA: begin
					n.left_on = pwdata[dmfe_pkg::BIT_LEFT_ON];
					n.right_on = pwdata[dmfe_pkg::BIT_RIGHT_ON];
				end
				dmfe_pkg::IDX_VOL_L: begin
					n.stored.left = pwdata[dmfe_pkg::VOL_W-1:0];
				end
				dmfe_pkg::IDX_VOL_R: begin
					n.stored.right = pwdata[dmfe_pkg::VOL_W-1:0];
				end
				dmfe_pkg::IDX_SRC_SEL: begin
					n.src_mic = pwdata[dmfe_pkg::BIT_SRC];
				end
				dmfe_pkg::IDX_CFG: begin
					n.osr64 = pwdata[dmfe_pkg::BIT_OSR64];
					n.clk_on = pwdata[dmfe_pkg::BIT_CLK_ON];
				end
				dmfe_pkg::IDX_STAT: begin
					if (pwdata[dmfe_pkg::BIT_OVR]) begin
						n.ovr = 1'b0;
					end
				end
				default: n.ovr = n.ovr;
			endcase
		end

		// pending update is taken at the next sample boundary
		if (q.pend && boundary) begin
			n.active = q.stored;
			n.pend = 1'b0;
		end
		if (wr_take && pwdata[dmfe_pkg::BIT_VU] &&
			(idx == dmfe_pkg::IDX_VOL_L || idx == dmfe_pkg::IDX_VOL_R)) begin
			n.pend = 1'b1;
		end

		// a stalled gain stage loses the sample; set wins over clear
		if (src_valid && !g_ready) begin
			n.ovr = 1'b1;
		end

		// phase clock divider and mid-phase data pick
		if (!q.clk_on) begin
			n.div = '0;
			n.phase = 1'b0;
			n.ones_l = '0;
			n.ones_r = '0;
			n.nbits = '0;
			n.armed = 1'b0;
		end else begin
			if (q.div == CNT_W'(dmfe_pkg::HALF_CYC - 1)) begin
				n.div = '0;
				n.phase = !q.phase;
			end else begin
				n.div = q.div + CNT_W'(1);
			end
			// sync delay is folded into the pick point
			if (q.div == CNT_W'(dmfe_pkg::PICK_CYC)) begin
				// a low bit ahead of the first high bit has no partner
				if (q.phase) begin
					n.ones_l = q.ones_l + OSR_W'(q.sync[1]);
					n.armed = 1'b1;
				end else if (q.armed) begin
					n.ones_r = q.ones_r + OSR_W'(q.sync[1]);
					n.nbits = q.nbits + OSR_W'(1);
					if (q.nbits + OSR_W'(1) == osr_now) begin
						n.smp_vld = 1'b1;
						n.smp.left = to_pcm(q.ones_l, q.osr64);
						n.smp.right = to_pcm(q.ones_r + OSR_W'(q.sync[1]),
							q.osr64);
						n.ones_l = '0;
						n.ones_r = '0;
						n.nbits = '0;
					end
				end
			end
		end
	end

	// reset puts 0 dB into both the stored and the applied codes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.stored <= {dmfe_pkg::VOL_RESET, dmfe_pkg::VOL_RESET};
			q.active <= {dmfe_pkg::VOL_RESET, dmfe_pkg::VOL_RESET};
		end else begin
			q <= n;
		end
	end

	// same volume path for converter and microphone samples
	dmfe_gain u_gain (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(src_valid),
		.in_pair(gated),
		.gains(q.active),
		.in_ready(g_ready),
		.out_valid(g_valid),
		.out_pair(g_pair),
		.out_ready(b_ready)
	);

	// two words of slack so a brief receiver stall costs nothing
	dmfe_buf #(
		.W(2 * dmfe_pkg::SAMPLE_W),
		.DEPTH(2)
	) u_buf (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(g_valid),
		.in_data(g_pair),
		.in_ready(b_ready),
		.out_valid(rec_valid),
		.out_data(rec_pair),
		.out_ready(rec_ready)
	);
endmodule
`default_nettype wire

// *** testbench/dmfe_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmfe_chk (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb
	input wire logic [dmfe_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// outputs under watch
	input wire logic mic_phase_clock,
	input wire logic left_conv_on,
	input wire logic right_conv_on,
	input wire logic conv_osr64,
	input wire logic rec_valid,
	input wire dmfe_pkg::dmfe_pair_t rec_pair,
	input wire logic rec_ready
);
	logic wr;
	logic [9:0] idx;
	logic mapped;
	// completed write and decode of its index
	assign wr = psel && penable && pwrite && pready;
	assign idx = paddr[11:2];
	assign mapped = idx inside {dmfe_pkg::IDX_CONV_ENA, dmfe_pkg::IDX_VOL_L,
		dmfe_pkg::IDX_VOL_R, dmfe_pkg::IDX_SRC_SEL, dmfe_pkg::IDX_CFG,
		dmfe_pkg::IDX_STAT};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_low;
		!mic_phase_clock [*5];
	endsequence
	// a clock turned off mid-phase may end early, so only overlong is fatal
	a_phase_long: assert property (mic_phase_clock [*5] |=> !mic_phase_clock)
		else $error("phase clock high too long");
	a_phase_low: assert property ($fell(mic_phase_clock) |-> s_low)
		else $error("phase clock low phase wrong");
	a_phase_off: assert property (wr && idx == dmfe_pkg::IDX_CFG && !pwdata[1]
		|=> ##1 !mic_phase_clock)
		else $error("phase clock not held low");
	a_apb_answer: assert property (s_setup |=> pready)
		else $error("no answer after setup");
	a_slverr_map: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong for index");
	a_enable_write: assert property (wr && idx == dmfe_pkg::IDX_CONV_ENA
		|=> {left_conv_on, right_conv_on} == $past(pwdata[1:0]))
		else $error("enables differ from write");
	a_enable_hold: assert property (!(wr && idx == dmfe_pkg::IDX_CONV_ENA)
		|=> $stable({left_conv_on, right_conv_on}))
		else $error("enables moved without write");
	a_osr_write: assert property (wr && idx == dmfe_pkg::IDX_CFG
		|=> conv_osr64 == $past(pwdata[0]))
		else $error("oversampling select wrong");
	a_rec_hold: assert property (rec_valid && !rec_ready
		|=> rec_valid && $stable(rec_pair))
		else $error("record word dropped while stalled");
endmodule
`default_nettype wire

// *** testbench/dmfe_mic.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmfe_mic (
	// link
	input wire logic mic_phase_clock,
	output logic mic_serial_in,
	// constant levels sent by each microphone
	input wire logic first_bit,
	input wire logic second_bit
);
	// the line carries first_bit in the high phase and second_bit in the low phase, 3 ns after each edge; it never floats
	always @(mic_phase_clock) begin
		#3 mic_serial_in = mic_phase_clock ? first_bit : second_bit;
	end
	initial mic_serial_in = 1'b0;
endmodule
`default_nettype wire

// *** testbench/dmic_record_front_end_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmic_record_front_end_tb_top;
	logic clk_sys = 0;
	logic reset_n = 0;
	logic [dmfe_pkg::ADDR_W-1:0] paddr = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mic_serial_in;
	logic mic_phase_clock;
	logic conv_valid = 0;
	logic rec_ready = 0;
	logic rec_valid;
	dmfe_pkg::dmfe_pair_t conv_pair = 0;
	dmfe_pkg::dmfe_pair_t rec_pair;
	logic left_conv_on;
	logic right_conv_on;
	logic conv_osr64;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h97E5;
	logic [31:0] rd;
	logic er;
	logic [63:0] x;
	logic [47:0] expq[$];
	logic [7:0] gl = 8'hC0;
	logic [7:0] gr = 8'hC0;
	logic [7:0] sl = 8'hC0;
	logic [7:0] sr = 8'hC0;
	logic pend = 0;
	logic stall = 0;
	time t0;

	always #20 clk_sys = ~clk_sys;

	dmfe_top dut (.clk_sys, .reset_n, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .mic_serial_in,
		.mic_phase_clock, .conv_valid, .conv_pair, .left_conv_on,
		.right_conv_on, .conv_osr64, .rec_valid, .rec_pair, .rec_ready);
	dmfe_mic u_mic (.mic_phase_clock, .mic_serial_in,
		.first_bit(1'b1), .second_bit(1'b0));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// gain model: only mute and exact power-of-two codes are used here
	function automatic logic [23:0] g(input logic [23:0] s, input logic [7:0] c);
		int v;
		v = c == 8'h00 ? 0 : $signed(s) * (c == 8'hE0 ? 4 : c == 8'hD0 ? 2 : 1);
		if (v > 32'sh007FFFFF)
			v = 32'sh007FFFFF;
		if (v < -32'sh00800000)
			v = -32'sh00800000;
		return v[23:0];
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one apb transfer; pready is looked at on rising edges only
	task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rchk(input logic [9:0] i, input logic [31:0] e);
		apb(0, i, 32'h0);
		chk({16'h0, rd}, {16'h0, e});
	endtask

	// stored and applied codes tracked as the update strobe says
	task automatic vol(input logic [9:0] i, input logic [8:0] d);
		apb(1, i, {23'h0, d});
		if (i == dmfe_pkg::IDX_VOL_L)
			sl = d[7:0];
		else
			sr = d[7:0];
		if (d[8])
			pend = 1;
	endtask

	// at most three in flight: gain stage plus the two-entry buffer
	task automatic send(input logic [47:0] p);
		while (expq.size() > 2)
			@(posedge clk_sys);
		@(posedge clk_sys);
		conv_valid <= 1;
		conv_pair <= p;
		@(posedge clk_sys);
		conv_valid <= 0;
		expq.push_back({g(p[47:24], gl), g(p[23:0], gr)});
		if (pend) begin
			gl = sl;
			gr = sr;
			pend = 0;
		end
	endtask

	task automatic drain();
		while (expq.size() != 0)
			@(posedge clk_sys);
	endtask

	task automatic rnd_send(input int n);
		repeat (n) begin
			x = {rnd(), rnd()};
			send(x[47:0]);
		end
	endtask

	// two mic frames: all ones left, all zeros right, and their spacing
	task automatic mic(input int n);
		expq.push_back(48'h7FFFFF800000);
		drain();
		t0 = $time;
		expq.push_back(48'h7FFFFF800000);
		drain();
		chk(($time - t0) / 40, n);
	endtask

	// sink stalls at random while stall is set
	always @(posedge clk_sys)
		rec_ready <= stall ? ^rnd() : 1'b1;

	// every word taken is compared with the model's next word
	always @(negedge clk_sys) begin
		if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
			if (expq.size() == 0)
				chk(48'h1, 48'h0);
			else
				chk(rec_pair, expq.pop_front());
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1;
		rchk(dmfe_pkg::IDX_CONV_ENA, 32'h0);
		rchk(dmfe_pkg::IDX_VOL_L, 32'hC0);
		rchk(dmfe_pkg::IDX_VOL_R, 32'hC0);
		rchk(dmfe_pkg::IDX_SRC_SEL, 32'h0);
		rchk(10'h3FF, 32'h0);
		chk({47'h0, er}, 48'h1);
		for (int k = 1; k < 4; k++) begin
			apb(1, dmfe_pkg::IDX_CONV_ENA, k);
			@(negedge clk_sys);
			chk({46'h0, left_conv_on, right_conv_on}, k);
		end
		stall = 1;
		rnd_send(6);
		vol(dmfe_pkg::IDX_VOL_L, 9'h0D0);
		rchk(dmfe_pkg::IDX_VOL_L, 32'hD0);
		rnd_send(2);
		vol(dmfe_pkg::IDX_VOL_R, 9'h1E0);
		rchk(dmfe_pkg::IDX_STAT, 32'h2);
		rnd_send(3);
		vol(dmfe_pkg::IDX_VOL_L, 9'h100);
		rnd_send(3);
		vol(dmfe_pkg::IDX_VOL_L, 9'h0C0);
		vol(dmfe_pkg::IDX_VOL_R, 9'h1C0);
		rnd_send(2);
		drain();
		stall = 0;
		apb(1, dmfe_pkg::IDX_SRC_SEL, 32'h200);
		rchk(dmfe_pkg::IDX_SRC_SEL, 32'h200);
		apb(1, dmfe_pkg::IDX_CFG, 32'h2);
		// a converter word now must be ignored
		@(posedge clk_sys);
		conv_valid <= 1;
		@(posedge clk_sys);
		conv_valid <= 0;
		mic(1280);
		apb(1, dmfe_pkg::IDX_CFG, 32'h0);
		apb(1, dmfe_pkg::IDX_CFG, 32'h3);
		mic(640);
		apb(1, dmfe_pkg::IDX_CFG, 32'h0);
		repeat (4) @(posedge clk_sys);
		stop_test();
	end

	// watchdog well past the expected run of about 4000 cycles
	initial begin
		#1200000;
		fail_count++;
		stop_test();
	end
endmodule

bind dmfe_top dmfe_chk u_chk (.clk_sys, .reset_n, .paddr, .psel, .penable,
	.pwrite, .pwdata, .pready, .pslverr, .mic_phase_clock, .left_conv_on,
	.right_conv_on, .conv_osr64, .rec_valid, .rec_pair, .rec_ready);
`default_nettype wire
